// ### design/dual_pll_control_latches.sv
// Serial input register, four control latches, power-down sequencing and APB view.
// Overview of operation
// (RL1) IF tristated then powerdown: immediate power-down
// (RL2) RF powerdown with pump active: tristate first
// (RL3) RF tristated then powerdown: immediate power-down
// (RL4) Power-down loads dividers, input goes high-impedance
// (RL5) Oscillator off only when both sections down; code stops it once both powerdown bits latch
// (RL6) Shift register and latches work when down
// (RL7) Writing powerdown zero wakes section at once
// (RL8) Select 00 loads IF reference latch
// (RL9) IF polarity bit sets phase detector sense
// (RL10) IF tristate bit floats IF charge pump
// (RL11) IF pump current from three-bit field
// (RL12) Select 01 loads IF swallow/main divider
// (RL13) IF prescaler from two-bit field
// (RL14) IF fast acquisition forces maximum current
// (RL15) Select 10 loads RF reference latch
// (RL16) RF polarity bit sets phase detector sense
// (RL17) RF tristate bit floats RF charge pump
// (RL18) RF pump current from three-bit field
// (RL19) Select 11 loads RF swallow/main divider
// (RL20) RF prescaler from two-bit field
// (RL21) RF fast acquisition forces maximum current
// (RL22) RF fast acquisition closes damping switch
// (RL23) MSB first, one bit per clock rise
// (RL24) Latch copies word on strobe rise only; an APB write to ADDR_SW_WORD also loads one
// (RL25) Select code is word bits one, zero
// (RL26) IF powerdown with pump active: tristate first

module section_power
  import pll_ctrl_pkg::*;
(
  input logic pclk,
  input logic presetn,
  input logic [WORD_W-1:0] r_word,
  input logic [WORD_W-1:0] n_word,
  input logic n_load,
  output pwr_state_e state_q,
  output sec_ctl_s ctl_q
);

  logic pd_bit;
  logic tri_bit;
  logic fast_bit;
  pwr_state_e state_d;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  sec_ctl_s ctl_d;
  logic down;

  assign pd_bit = n_word[PD_BIT];
  assign tri_bit = r_word[TRI_BIT];
  assign fast_bit = n_word[FAST_BIT];
  assign down = (state_q == PWR_DOWN);

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    unique case (state_q)
      PWR_UP: begin
        if (n_load && pd_bit) begin
          // (RL1) (RL3) Pump already floating: go down now.
          if (tri_bit) begin
            state_d = PWR_DOWN;
          end else begin
            // (RL2) Synchronous sequence start.
            // (RL26) Same sequence for IF.
            state_d = PWR_CP_OFF;
            cnt_d = SETTLE_LAST;
          end
        end
      end
      PWR_CP_OFF: begin
        if (cnt_q == 8'h00) begin
          state_d = PWR_DOWN;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      PWR_DOWN: begin
        state_d = PWR_DOWN;
      end
      default: begin
        state_d = PWR_UP;
      end
    endcase
    // (RL7) Cleared bit wakes at once.
    if (!pd_bit) begin
      state_d = PWR_UP;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= PWR_UP;
      cnt_q <= 8'h00;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // (RL11) (RL18) Current field, (RL14) (RL21) overridden by fast acquisition.
  assign ctl_d.cp_current = fast_bit ? CUR_MAX : r_word[CUR_LSB +: CUR_W];
  // (RL10) Tristate bit, (RL17) or any power-down phase floats the pump.
  assign ctl_d.cp_tristate = tri_bit | (state_q != PWR_UP);
  // (RL9) Polarity, (RL16) same for RF.
  assign ctl_d.pd_polarity = r_word[POL_BIT];
  assign ctl_d.ref_div = r_word[REF_LSB +: REF_W];
  assign ctl_d.b_count = n_word[B_LSB +: B_W];
  assign ctl_d.a_count = n_word[A_LSB +: A_W];
  // (RL13) Prescaler field, (RL20) same for RF.
  assign ctl_d.prescaler_sel = n_word[PSC_LSB +: 2];
  assign ctl_d.fast_acq = fast_bit;
  // (RL4) Down forces load state and high impedance.
  assign ctl_d.div_load = down;
  assign ctl_d.input_hiz = down;
  assign ctl_d.powered_down = down;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= '0;
    end else begin
      ctl_q <= ctl_d;
    end
  end

endmodule : section_power

module dual_pll_control_latches
  import pll_ctrl_pkg::*;
(
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input serial_in_s link_i,
  output sec_ctl_s if_ctl,
  output sec_ctl_s rf_ctl,
  output logic reference_input_osc_en,
  output logic fast_acq_switch_out
);

  logic [2:0] sclk_q;
  logic [1:0] sdata_q;
  logic [2:0] strobe_q;
  logic sclk_rise;
  logic ld_edge;
  logic [WORD_W-1:0] shift_q;
  logic [WORD_W-1:0] latch_q [4];
  logic [WORD_W-1:0] load_word;
  logic load_req;
  latch_sel_e load_sel;
  logic if_n_load_q;
  logic rf_n_load_q;
  pwr_state_e if_state;
  pwr_state_e rf_state;
  logic osc_en_q;
  logic fast_sw_q;
  logic apb_access;
  logic hit_sw;
  logic hit_if_r;
  logic hit_if_n;
  logic hit_rf_r;
  logic hit_rf_n;
  logic hit_st;
  logic any_hit;
  logic apb_ld;
  logic [31:0] status_word;
  logic [31:0] rdata_d;
  logic [31:0] prdata_q;

  // Link pins pass two flops; the third stage only serves edge detection.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_q <= 3'h0;
      sdata_q <= 2'h0;
      strobe_q <= 3'h0;
    end else begin
      sclk_q <= {sclk_q[1:0], link_i.sclk};
      sdata_q <= {sdata_q[0], link_i.sdata};
      strobe_q <= {strobe_q[1:0], link_i.load_strobe};
    end
  end

  assign sclk_rise = sclk_q[1] & ~sclk_q[2];
  assign ld_edge = strobe_q[1] & ~strobe_q[2];

  // (RL23) MSB first, one bit per serial clock rise.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_q <= LATCH_RST;
    end else if (sclk_rise) begin
      shift_q <= {shift_q[WORD_W-2:0], sdata_q[1]};
    end
  end

  // A software word takes the same path as a strobed one; pready holds it off
  // during a strobe edge so the two never collide.
  assign apb_access = psel & penable;
  assign pready = ~ld_edge;
  // (RL24) Copy on strobe rise or on an APB write to ADDR_SW_WORD.
  assign load_req = ld_edge | apb_ld;
  assign load_word = ld_edge ? shift_q : pwdata[WORD_W-1:0];
  // (RL25) Select code from the two lowest bits.
  assign load_sel = latch_sel_e'(load_word[SEL_LSB +: SEL_W]);

  // (RL8) (RL12) (RL15) (RL19) One latch per select code.
  // (RL6) Loading never depends on power state.
  for (genvar i = 0; i < 4; i++) begin : g_latch
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        latch_q[i] <= LATCH_RST;
      end else if (load_req && (load_sel == latch_sel_e'(i))) begin
        latch_q[i] <= load_word;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      if_n_load_q <= 1'b0;
      rf_n_load_q <= 1'b0;
    end else begin
      if_n_load_q <= load_req && (load_sel == SEL_IF_N);
      rf_n_load_q <= load_req && (load_sel == SEL_RF_N);
    end
  end

  section_power u_if (
    .pclk(pclk),
    .presetn(presetn),
    .r_word(latch_q[SEL_IF_R]),
    .n_word(latch_q[SEL_IF_N]),
    .n_load(if_n_load_q),
    .state_q(if_state),
    .ctl_q(if_ctl)
  );

  section_power u_rf (
    .pclk(pclk),
    .presetn(presetn),
    .r_word(latch_q[SEL_RF_R]),
    .n_word(latch_q[SEL_RF_N]),
    .n_load(rf_n_load_q),
    .state_q(rf_state),
    .ctl_q(rf_ctl)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_en_q <= 1'b1;
      fast_sw_q <= 1'b0;
    end else begin
      // (RL5) Oscillator stops only with both bits set.
      osc_en_q <= ~(latch_q[SEL_IF_N][PD_BIT] & latch_q[SEL_RF_N][PD_BIT]);
      // (RL22) Damping switch follows RF fast acquisition.
      fast_sw_q <= latch_q[SEL_RF_N][FAST_BIT];
    end
  end

  assign reference_input_osc_en = osc_en_q;
  assign fast_acq_switch_out = fast_sw_q;

  assign hit_sw = (paddr == ADDR_SW_WORD);
  assign hit_if_r = (paddr == ADDR_IF_R);
  assign hit_if_n = (paddr == ADDR_IF_N);
  assign hit_rf_r = (paddr == ADDR_RF_R);
  assign hit_rf_n = (paddr == ADDR_RF_N);
  assign hit_st = (paddr == ADDR_STATUS);
  assign any_hit = hit_sw | hit_if_r | hit_if_n | hit_rf_r | hit_rf_n | hit_st;
  assign pslverr = apb_access & ~any_hit;
  assign apb_ld = apb_access & pready & pwrite & hit_sw;

  assign status_word = {26'h0, fast_sw_q, osc_en_q, rf_state, if_state};
  assign rdata_d = hit_sw ? {8'h00, shift_q} :
                   hit_if_r ? {8'h00, latch_q[SEL_IF_R]} :
                   hit_if_n ? {8'h00, latch_q[SEL_IF_N]} :
                   hit_rf_r ? {8'h00, latch_q[SEL_RF_R]} :
                   hit_rf_n ? {8'h00, latch_q[SEL_RF_N]} :
                   hit_st ? status_word : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (psel && !pwrite) begin
      prdata_q <= rdata_d;
    end
  end

  assign prdata = prdata_q;

  localparam int SETTLE_END = PD_SETTLE_CYC + 4;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_if_async_down: assert property ( // RL1
    ld_edge && shift_q[SEL_LSB +: SEL_W] == SEL_IF_N && shift_q[PD_BIT]
      && latch_q[SEL_IF_R][TRI_BIT] && !if_ctl.powered_down
    |-> ##3 if_ctl.powered_down)
    else $error("IF asynchronous power-down late");

  a_rf_sync_seq: assert property ( // RL2
    ld_edge && shift_q[SEL_LSB +: SEL_W] == SEL_RF_N && shift_q[PD_BIT]
      && !latch_q[SEL_RF_R][TRI_BIT] && rf_state == PWR_UP
    |-> ##3 (rf_ctl.cp_tristate && !rf_ctl.powered_down)
      ##[1:SETTLE_END] rf_ctl.powered_down)
    else $error("RF synchronous power-down order wrong");

  a_rf_async_down: assert property ( // RL3
    ld_edge && shift_q[SEL_LSB +: SEL_W] == SEL_RF_N && shift_q[PD_BIT]
      && latch_q[SEL_RF_R][TRI_BIT]
    |-> ##3 rf_ctl.powered_down)
    else $error("RF asynchronous power-down late");

  a_down_loads_div: assert property ( // RL4
    rf_state == PWR_DOWN |=> rf_ctl.div_load && rf_ctl.input_hiz && rf_ctl.cp_tristate)
    else $error("RF down without divider load or high impedance");

  a_osc_both_down: assert property ( // RL5
    $past(latch_q[SEL_IF_N][PD_BIT]) && !$past(latch_q[SEL_RF_N][PD_BIT])
    |-> reference_input_osc_en)
    else $error("Oscillator stopped with one section down");

  a_latch_while_down: assert property ( // RL6
    load_req && if_ctl.powered_down && load_word[SEL_LSB +: SEL_W] == SEL_IF_N
    |=> latch_q[SEL_IF_N] == $past(load_word))
    else $error("IF divider latch ignored load while down");

  a_wake_on_zero: assert property ( // RL7
    load_req && load_word[SEL_LSB +: SEL_W] == SEL_IF_N && !load_word[PD_BIT]
    |-> ##3 !if_ctl.powered_down)
    else $error("IF section did not wake");

  a_fast_max_cur: assert property ( // RL21
    latch_q[SEL_RF_N][FAST_BIT] |=> rf_ctl.cp_current == CUR_MAX && fast_acq_switch_out)
    else $error("RF fast acquisition not applied");

  a_shift_msb_first: assert property ( // RL23
    sclk_rise |=> shift_q == {$past(shift_q[WORD_W-2:0]), $past(sdata_q[1])})
    else $error("Serial bit not shifted in");

  a_if_down_loads: assert property ( // RL4
    if_state == PWR_DOWN |=> if_ctl.div_load && if_ctl.input_hiz && if_ctl.cp_tristate)
    else $error("IF down without divider load or high impedance");

  a_rf_latch_down: assert property ( // RL6
    load_req && rf_ctl.powered_down && load_word[SEL_LSB +: SEL_W] == SEL_RF_N
    |=> latch_q[SEL_RF_N] == $past(load_word))
    else $error("RF divider latch ignored load while down");

  a_rf_wake_zero: assert property ( // RL7
    load_req && load_word[SEL_LSB +: SEL_W] == SEL_RF_N && !load_word[PD_BIT]
    |-> ##3 !rf_ctl.powered_down)
    else $error("RF section did not wake");

  a_if_fast_cur: assert property ( // RL14
    latch_q[SEL_IF_N][FAST_BIT] |=> if_ctl.cp_current == CUR_MAX)
    else $error("IF fast acquisition not applied");

  a_switch_off: assert property ( // RL22
    !latch_q[SEL_RF_N][FAST_BIT] |=> !fast_acq_switch_out)
    else $error("Damping switch closed without fast acquisition");

  a_ref_latch_hold: assert property ( // RL24
    !(load_req && load_sel == SEL_RF_R) |=> $stable(latch_q[SEL_RF_R]))
    else $error("RF reference latch changed without a load");

  a_rf_polarity: assert property ( // RL16
    1'b1 |=> rf_ctl.pd_polarity == $past(latch_q[SEL_RF_R][POL_BIT]))
    else $error("RF phase detector sense not from latch");

  a_rf_prescaler: assert property ( // RL20
    1'b1 |=> rf_ctl.prescaler_sel == $past(latch_q[SEL_RF_N][PSC_LSB +: 2]))
    else $error("RF prescaler select not from latch");

endmodule : dual_pll_control_latches

// ### design/pll_ctrl_pkg.sv
// Shared constants, types and field layout of the dual synthesizer control latches.
package pll_ctrl_pkg;

  localparam int WORD_W = 24;
  localparam logic [WORD_W-1:0] LATCH_RST = 24'h000000;

  // Field positions inside a 24-bit serial word.
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 2;
  localparam int REF_LSB = 2;
  localparam int REF_W = 14;
  localparam int POL_BIT = 17;
  localparam int TRI_BIT = 18;
  localparam int CUR_LSB = 21;
  localparam int CUR_W = 3;
  localparam int A_LSB = 2;
  localparam int A_W = 6;
  localparam int B_LSB = 8;
  localparam int B_W = 12;
  localparam int PSC_LSB = 20;
  localparam int PD_BIT = 22;
  localparam int FAST_BIT = 23;

  localparam logic [CUR_W-1:0] CUR_MAX = 3'h7;

  typedef enum logic [1:0] {
    SEL_IF_R = 2'b00,
    SEL_IF_N = 2'b01,
    SEL_RF_R = 2'b10,
    SEL_RF_N = 2'b11
  } latch_sel_e;

  typedef enum logic [1:0] {
    PWR_UP = 2'b00,
    PWR_CP_OFF = 2'b01,
    PWR_DOWN = 2'b10
  } pwr_state_e;

  // Time the charge pump stays three-stated before a synchronous power-down completes.
  localparam int CLK_PERIOD_NS = 4;
  localparam int PD_SETTLE_NS = 100;
  localparam int PD_SETTLE_CYC = (PD_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] SETTLE_LAST = 8'(PD_SETTLE_CYC - 1);

  // APB register byte addresses.
  localparam logic [7:0] ADDR_SW_WORD = 8'h00;
  localparam logic [7:0] ADDR_IF_R = 8'h04;
  localparam logic [7:0] ADDR_IF_N = 8'h08;
  localparam logic [7:0] ADDR_RF_R = 8'h0C;
  localparam logic [7:0] ADDR_RF_N = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;

  typedef struct packed {
    logic sclk;
    logic sdata;
    logic load_strobe;
  } serial_in_s;

  typedef struct packed {
    logic [REF_W-1:0] ref_div;
    logic [B_W-1:0] b_count;
    logic [A_W-1:0] a_count;
    logic [1:0] prescaler_sel;
    logic pd_polarity;
    logic cp_tristate;
    logic [CUR_W-1:0] cp_current;
    logic fast_acq;
    logic div_load;
    logic input_hiz;
    logic powered_down;
  } sec_ctl_s;

endpackage : pll_ctrl_pkg

// ### testbench/host_serial_model.sv
// Host side of the three-wire link: shifts one word and then pulses the load strobe.
module host_serial_model
  import pll_ctrl_pkg::*;
(
  output serial_in_s link_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    link_o = '0;
  end

  task automatic send(input logic [WORD_W-1:0] w);
    int i;
    #13;
    for (i = WORD_W - 1; i >= 0; i--) begin
      link_o.sdata = w[i];
      #40;
      link_o.sclk = 1'b1;
      #40;
      link_o.sclk = 1'b0;
    end
    // The data line does not keep its last bit once the frame is over.
    link_o.sdata = ~w[0];
    #40;
    link_o.load_strobe = 1'b1;
    #80;
    link_o.load_strobe = 1'b0;
  endtask : send
endmodule : host_serial_model

// ### testbench/test_dual_pll_control_latches.sv
// Self-checking bench for the dual synthesizer control latches.
module test_dual_pll_control_latches
  import pll_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [23:0] IFR_W = {3'h5, 2'h0, 1'h1, 1'h1, 1'h0, 14'h02A5, 2'h0};
  localparam logic [23:0] IFN_W = {1'h0, 1'h1, 2'h2, 12'hABC, 6'h15, 2'h1};
  localparam logic [23:0] RFR_W = {3'h3, 3'h0, 1'h1, 1'h0, 14'h0100, 2'h2};
  localparam logic [23:0] RFN_W = {1'h0, 1'h1, 2'h1, 12'h123, 6'h3F, 2'h3};
  localparam logic [23:0] RFF_W = {1'h1, 1'h0, 2'h3, 12'hFFF, 6'h00, 2'h3};
  localparam logic [23:0] IFF_W = {1'h1, 1'h0, 2'h0, 12'h001, 6'h01, 2'h1};
  localparam logic [23:0] RFT_W = {3'h3, 2'h0, 1'h1, 1'h1, 1'h0, 14'h0100, 2'h2};

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, osc_en, fast_sw;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  serial_in_s link;
  sec_ctl_s if_ctl, rf_ctl;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;

  dual_pll_control_latches dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .link_i(link),
    .if_ctl(if_ctl),
    .rf_ctl(rf_ctl),
    .reference_input_osc_en(osc_en),
    .fast_acq_switch_out(fast_sw)
  );

  host_serial_model host (
    .link_o(link)
  );

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      final_report();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask : cyc

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(ADDR_STATUS, 1'b0, 32'h0);
    check(rd, 32'h10);
    apb(8'h2C, 1'b0, 32'h0);
    check(32'(er), 32'h1);
    check(rd, 32'h0);
    $display("test reset_and_map done");
    host.send(IFR_W);
    cyc(1);
    check(32'(if_ctl.ref_div), 32'h2A5);
    check(32'(if_ctl.pd_polarity), 32'h1);
    check(32'(if_ctl.cp_tristate), 32'h1);
    check(32'(if_ctl.cp_current), 32'h5);
    check(32'(rf_ctl.ref_div), 32'h0);
    apb(ADDR_IF_R, 1'b0, 32'h0);
    check(rd, 32'(IFR_W));
    $display("test if_reference done");
    host.send(IFN_W);
    cyc(1);
    check(32'(if_ctl.powered_down), 32'h1);
    check(32'({if_ctl.div_load, if_ctl.input_hiz}), 32'h3);
    check(32'({if_ctl.b_count, if_ctl.a_count}), 32'h2AF15);
    check(32'(if_ctl.prescaler_sel), 32'h2);
    check(32'(osc_en), 32'h1);
    $display("test if_async_powerdown done");
    host.send(RFR_W);
    cyc(1);
    check(32'(rf_ctl.ref_div), 32'h100);
    check(32'(rf_ctl.pd_polarity), 32'h1);
    check(32'(rf_ctl.cp_tristate), 32'h0);
    check(32'(rf_ctl.cp_current), 32'h3);
    host.send(RFN_W);
    cyc(1);
    check(32'({rf_ctl.cp_tristate, rf_ctl.powered_down}), 32'h2);
    check(32'({rf_ctl.b_count, rf_ctl.a_count}), 32'h48FF);
    check(32'(rf_ctl.prescaler_sel), 32'h1);
    cyc(20);
    check(32'({rf_ctl.powered_down, rf_ctl.input_hiz, rf_ctl.div_load}), 32'h7);
    check(32'(osc_en), 32'h0);
    $display("test rf_sync_powerdown done");
    host.send(RFF_W);
    cyc(1);
    check(32'(rf_ctl.powered_down), 32'h0);
    check(32'(rf_ctl.b_count), 32'hFFF);
    check(32'({rf_ctl.fast_acq, rf_ctl.cp_current}), 32'hF);
    check(32'(fast_sw), 32'h1);
    check(32'(osc_en), 32'h1);
    apb(ADDR_SW_WORD, 1'b1, 32'(IFF_W));
    cyc(5);
    check(32'({if_ctl.fast_acq, if_ctl.cp_current}), 32'hF);
    check(32'(if_ctl.powered_down), 32'h0);
    $display("test wake_and_fast done");
    apb(ADDR_SW_WORD, 1'b1, 32'(RFT_W));
    cyc(5);
    check(32'(rf_ctl.cp_tristate), 32'h1);
    host.send(RFN_W);
    cyc(1);
    check(32'(rf_ctl.powered_down), 32'h1);
    check(32'(rf_ctl.cp_current), 32'h3);
    check(32'(fast_sw), 32'h0);
    $display("test rf_async_powerdown done");
    final_report();
  end
endmodule : test_dual_pll_control_latches
